// [logic/edd_dma.sv]
`timescale 1ns/1ps
module edd_dma #(
    parameter logic [31:0] SRAM_BASE = 32'h2000_0000,
    parameter logic [31:0] SRAM_SIZE = 32'h0004_0000
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // system memory
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_err,
    // transmit stream to the mac
    output logic [31:0]      tx_data,
    output logic             tx_last,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // receive stream from the mac
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_last,
    input  wire logic        rx_err,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    // frame timestamp
    input  wire logic [63:0] ts_in
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic chained(edd_pkg::edd_eng_t g, logic rx);
        chained = rx ? g.w1[edd_pkg::RX_CHAIN] : g.w0[edd_pkg::TX_CHAIN];
    endfunction

    function automatic logic wraps(edd_pkg::edd_eng_t g, logic rx);
        wraps = rx ? g.w1[edd_pkg::RX_WRAP] : g.w0[edd_pkg::TX_WRAP];
    endfunction

    function automatic logic buf2_ok(edd_pkg::edd_eng_t g, logic rx);
        buf2_ok = !g.sel && !chained(g, rx) && (g.w1[edd_pkg::SZ2 +: 13] != 13'h0000);
    endfunction

    function automatic logic in_sram(logic [31:0] a);
        in_sram = (a >= SRAM_BASE) && ((a - SRAM_BASE) < SRAM_SIZE);
    endfunction

    function automatic logic [31:0] wmask(logic [3:0] s);
        wmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // memory operation wanted by an engine: {want, we, addr, wdata}
    function automatic logic [65:0] memop(edd_pkg::edd_eng_t g, logic rx, logic enh, logic [63:0] ts);
        logic [31:0] wb;
        wb = 32'h0000_0000;
        if (rx) begin
            wb[edd_pkg::RX_LEN +: 14] = g.cnt;
            wb[edd_pkg::RX_ES] = g.err;
            wb[edd_pkg::RX_FS] = g.fs;
            wb[edd_pkg::RX_LS] = g.last;
            wb[edd_pkg::RX_TS] = enh && g.last;
        end else begin
            wb = g.w0;
            wb[edd_pkg::TX_TS] = enh && g.last;
        end
        wb[edd_pkg::OWN_BIT] = 1'b0;
        unique case (g.st)
            edd_pkg::S_D0:   memop = {2'b10, g.cur, 32'h0000_0000};
            edd_pkg::S_D1:   memop = {2'b10, g.cur + edd_pkg::OFS_W1, 32'h0000_0000};
            edd_pkg::S_D2:   memop = {2'b10, g.cur + edd_pkg::OFS_W2, 32'h0000_0000};
            edd_pkg::S_D3:   memop = {2'b10, g.cur + edd_pkg::OFS_W3, 32'h0000_0000};
            edd_pkg::S_XFER: memop = {!rx, 1'b0, g.ptr, 32'h0000_0000};
            edd_pkg::S_MOVE: memop = {rx, 1'b1, g.ptr, g.dat};
            edd_pkg::S_TSL:  memop = {2'b11, g.cur + edd_pkg::OFS_TS_LO, ts[31:0]};
            edd_pkg::S_TSH:  memop = {2'b11, g.cur + edd_pkg::OFS_TS_HI, ts[63:32]};
            edd_pkg::S_WB:   memop = {2'b11, g.cur, wb};
            default:         memop = {2'b00, 32'h0000_0000, 32'h0000_0000};
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    edd_pkg::edd_all_t q;
    edd_pkg::edd_all_t d;

    assign s_awready = !q.aw_ok && !q.bvalid;
    assign s_wready  = !q.w_ok && !q.bvalid;
    assign s_bvalid  = q.bvalid;
    assign s_bresp   = q.bresp;
    assign s_arready = !q.rvalid;
    assign s_rvalid  = q.rvalid;
    assign s_rdata   = q.rdata;
    assign s_rresp   = q.rresp;
    assign mem_req   = q.mreq;
    assign mem_we    = q.mwe;
    assign mem_addr  = q.maddr;
    assign mem_wdata = q.mwdata;
    assign tx_data   = q.eng[0].dat;
    assign tx_last   = q.eng[0].last;
    assign tx_valid  = q.eng[0].st == edd_pkg::S_MOVE;
    assign rx_ready  = q.eng[1].st == edd_pkg::S_XFER;

    always_comb begin
        logic [31:0] m;
        logic [31:0] stat;
        logic [65:0] op;
        logic        done;
        logic        enh;
        logic        en;
        logic        step;
        logic        rx;
        m    = 32'h0000_0000;
        stat = 32'h0000_0000;
        op   = 66'h0;
        done = 1'b0;
        enh  = q.ctrl[edd_pkg::CTRL_ENH];
        en   = 1'b0;
        step = 1'b0;
        rx   = 1'b0;
        d    = q;

        // --------------------------------------------------------
        // register bus
        // --------------------------------------------------------
        for (int e = 0; e < 2; e++) begin
            stat[edd_pkg::STAT_SUSP + e] = q.eng[e].st == edd_pkg::S_SUSP;
            stat[edd_pkg::STAT_BERR + e] = q.eng[e].berr;
            stat[edd_pkg::STAT_RUN + e]  = !(q.eng[e].st inside {edd_pkg::S_STOP, edd_pkg::S_SUSP, edd_pkg::S_ERR});
        end
        if (s_awvalid && s_awready) begin
            d.aw_ok = 1'b1;
            d.awa   = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            d.w_ok = 1'b1;
            d.wd   = s_wdata;
            d.ws   = s_wstrb;
        end
        if (q.aw_ok && q.w_ok) begin
            m        = wmask(q.ws);
            d.aw_ok  = 1'b0;
            d.w_ok   = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = edd_pkg::RESP_OKAY;
            unique case (q.awa)
                edd_pkg::REG_CTRL:    d.ctrl = (q.ctrl & ~m[2:0]) | (q.wd[2:0] & m[2:0]);
                edd_pkg::REG_TX_POLL: d.eng[0].poll = 1'b1;
                edd_pkg::REG_RX_POLL: d.eng[1].poll = 1'b1;
                edd_pkg::REG_TX_LIST: d.eng[0].base = (q.eng[0].base & ~m) | (q.wd & m);
                edd_pkg::REG_RX_LIST: d.eng[1].base = (q.eng[1].base & ~m) | (q.wd & m);
                edd_pkg::REG_TX_CUR, edd_pkg::REG_RX_CUR: ;
                edd_pkg::REG_STAT: begin
                    for (int e = 0; e < 2; e++) begin
                        if (q.wd[edd_pkg::STAT_BERR + e] && m[edd_pkg::STAT_BERR + e]) begin
                            d.eng[e].berr = 1'b0;
                        end
                    end
                end
                default: d.bresp = edd_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp  = edd_pkg::RESP_OKAY;
            unique case (s_araddr)
                edd_pkg::REG_CTRL:    d.rdata = {29'h0, q.ctrl};
                edd_pkg::REG_TX_POLL: d.rdata = 32'h0000_0000;
                edd_pkg::REG_RX_POLL: d.rdata = 32'h0000_0000;
                edd_pkg::REG_TX_LIST: d.rdata = q.eng[0].base;
                edd_pkg::REG_RX_LIST: d.rdata = q.eng[1].base;
                edd_pkg::REG_TX_CUR:  d.rdata = q.eng[0].cur;
                edd_pkg::REG_RX_CUR:  d.rdata = q.eng[1].cur;
                edd_pkg::REG_STAT:    d.rdata = stat;
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = edd_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_rready) begin
            d.rvalid = 1'b0;
        end

        // --------------------------------------------------------
        // descriptor engines, 0 transmit and 1 receive
        // --------------------------------------------------------
        for (int e = 0; e < 2; e++) begin
            rx   = e == 1;
            en   = q.ctrl[e];
            done = q.mreq && mem_ack && (q.msel == rx);
            step = 1'b0;
            if (done && mem_err) begin
                d.eng[e].berr = 1'b1;
                d.eng[e].st   = edd_pkg::S_ERR;
            end else begin
                unique case (q.eng[e].st)
                    edd_pkg::S_STOP: begin
                        d.eng[e].cur = d.eng[e].base;
                        if (en) begin
                            d.eng[e].st = edd_pkg::S_D0;
                        end
                    end
                    edd_pkg::S_SUSP: begin
                        if (!en) begin
                            d.eng[e].st = edd_pkg::S_STOP;
                        end else if (d.eng[e].poll) begin
                            d.eng[e].st = edd_pkg::S_D0;
                        end
                    end
                    edd_pkg::S_D0: begin
                        if (done) begin
                            d.eng[e].w0 = mem_rdata;
                            // software-owned: wait for a poll demand
                            d.eng[e].st = mem_rdata[edd_pkg::OWN_BIT] ? edd_pkg::S_D1 : edd_pkg::S_SUSP;
                        end
                    end
                    edd_pkg::S_D1: begin
                        if (done) begin
                            d.eng[e].w1 = mem_rdata;
                            d.eng[e].st = edd_pkg::S_D2;
                        end
                    end
                    edd_pkg::S_D2: begin
                        if (done) begin
                            d.eng[e].b1 = mem_rdata;
                            d.eng[e].st = edd_pkg::S_D3;
                        end
                    end
                    edd_pkg::S_D3: begin
                        if (done) begin
                            d.eng[e].b2 = mem_rdata;
                            d.eng[e].st = edd_pkg::S_CHK;
                        end
                    end
                    edd_pkg::S_CHK: begin
                        d.eng[e].sel  = 1'b0;
                        d.eng[e].ptr  = q.eng[e].b1;
                        d.eng[e].left = q.eng[e].w1[edd_pkg::SZ1 +: 13];
                        d.eng[e].st   = in_sram(q.eng[e].b1) ? edd_pkg::S_XFER : edd_pkg::S_ERR;
                        d.eng[e].berr = d.eng[e].berr | !in_sram(q.eng[e].b1);
                    end
                    edd_pkg::S_XFER: begin
                        if (!rx && done) begin
                            d.eng[e].dat  = mem_rdata;
                            d.eng[e].last = q.eng[e].w0[edd_pkg::TX_LS] && (q.eng[e].left <= edd_pkg::WORD_BYTES)
                                            && !buf2_ok(q.eng[e], rx);
                            d.eng[e].st   = edd_pkg::S_MOVE;
                        end else if (rx && rx_valid) begin
                            d.eng[e].dat  = rx_data;
                            d.eng[e].last = rx_last;
                            d.eng[e].err  = q.eng[e].err | rx_err;
                            d.eng[e].st   = edd_pkg::S_MOVE;
                        end
                    end
                    edd_pkg::S_MOVE: begin
                        step = rx ? done : tx_ready;
                        if (rx && done) begin
                            d.eng[e].cnt = q.eng[e].cnt + edd_pkg::CNT_STEP;
                        end
                    end
                    edd_pkg::S_TSL: begin
                        if (done) begin
                            d.eng[e].st = edd_pkg::S_TSH;
                        end
                    end
                    edd_pkg::S_TSH: begin
                        if (done) begin
                            d.eng[e].st = edd_pkg::S_WB;
                        end
                    end
                    edd_pkg::S_WB: begin
                        if (done) begin
                            d.eng[e].fs   = q.eng[e].last;
                            d.eng[e].last = 1'b0;
                            if (q.eng[e].last) begin
                                d.eng[e].cnt = 14'h0000;
                                d.eng[e].err = 1'b0;
                            end
                            if (wraps(q.eng[e], rx)) begin
                                d.eng[e].cur = q.eng[e].base;
                            end else if (chained(q.eng[e], rx)) begin
                                d.eng[e].cur = q.eng[e].b2;
                            end else begin
                                d.eng[e].cur = q.eng[e].cur + (enh ? edd_pkg::STRIDE_ENH : edd_pkg::STRIDE_BASIC);
                            end
                            d.eng[e].st = en ? edd_pkg::S_D0 : edd_pkg::S_STOP;
                        end
                    end
                    edd_pkg::S_ERR: begin
                        if (!en) begin
                            d.eng[e].st = edd_pkg::S_STOP;
                        end
                    end
                endcase
            end
            if (step) begin
                if (q.eng[e].last) begin
                    // in enhanced mode the timestamp words go out before the ownership clear
                    d.eng[e].st = enh ? edd_pkg::S_TSL : edd_pkg::S_WB;
                end else if (q.eng[e].left <= edd_pkg::WORD_BYTES) begin
                    if (buf2_ok(q.eng[e], rx)) begin
                        d.eng[e].sel  = 1'b1;
                        d.eng[e].ptr  = q.eng[e].b2;
                        d.eng[e].left = q.eng[e].w1[edd_pkg::SZ2 +: 13];
                        d.eng[e].st   = in_sram(q.eng[e].b2) ? edd_pkg::S_XFER : edd_pkg::S_ERR;
                        d.eng[e].berr = d.eng[e].berr | !in_sram(q.eng[e].b2);
                    end else begin
                        // frame goes on in the first buffer of the next descriptor
                        d.eng[e].st = edd_pkg::S_WB;
                    end
                end else begin
                    d.eng[e].ptr  = q.eng[e].ptr + edd_pkg::PTR_STEP;
                    d.eng[e].left = q.eng[e].left - edd_pkg::WORD_BYTES;
                    d.eng[e].st   = edd_pkg::S_XFER;
                end
            end
            // a demand seen while running is dropped in the same cycle; it is kept only while the engine is in S_SUSP
            if (d.eng[e].st != edd_pkg::S_SUSP) begin
                d.eng[e].poll = 1'b0;
            end
        end

        // --------------------------------------------------------
        // memory port, alternating between engines
        // --------------------------------------------------------
        if (q.mreq && mem_ack) begin
            d.mreq = 1'b0;
        end else if (!q.mreq) begin
            for (int k = 0; k < 2; k++) begin
                rx = k[0] ^ q.mown;
                op = memop(q.eng[rx], rx, enh, ts_in);
                if (!d.mreq && op[65] && (d.eng[rx].st == q.eng[rx].st)) begin
                    d.mreq   = 1'b1;
                    d.msel   = rx;
                    d.mown   = !rx;
                    d.mwe    = op[64];
                    d.maddr  = op[63:32];
                    d.mwdata = op[31:0];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q      <= '0;
            q.ctrl <= edd_pkg::CTRL_RESET;
            for (int e = 0; e < 2; e++) begin
                q.eng[e].st <= edd_pkg::S_STOP;
                q.eng[e].fs <= 1'b1;
            end
        end else begin
            q <= d;
        end
    end

endmodule

// [logic/edd_pkg.sv]
package edd_pkg;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_TX_POLL = 8'h04;
    localparam logic [7:0] REG_RX_POLL = 8'h08;
    localparam logic [7:0] REG_TX_LIST = 8'h0C;
    localparam logic [7:0] REG_RX_LIST = 8'h10;
    localparam logic [7:0] REG_TX_CUR  = 8'h14;
    localparam logic [7:0] REG_RX_CUR  = 8'h18;
    localparam logic [7:0] REG_STAT    = 8'h1C;

    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_ENH   = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // status: suspended at bit e, bus error at 2+e, running at 4+e
    localparam int STAT_SUSP = 0;
    localparam int STAT_BERR = 2;
    localparam int STAT_RUN  = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // descriptor layout
    // ------------------------------------------------------------
    localparam int OWN_BIT  = 31;
    localparam int TX_LS    = 29;
    localparam int TX_WRAP  = 21;
    localparam int TX_CHAIN = 20;
    localparam int TX_TS    = 17;
    localparam int RX_WRAP  = 15;
    localparam int RX_CHAIN = 14;
    localparam int RX_LEN   = 16;
    localparam int RX_ES    = 15;
    localparam int RX_FS    = 9;
    localparam int RX_LS    = 8;
    localparam int RX_TS    = 7;
    localparam int SZ1      = 0;
    localparam int SZ2      = 16;

    localparam logic [31:0] OFS_W1       = 32'h0000_0004;
    localparam logic [31:0] OFS_W2       = 32'h0000_0008;
    localparam logic [31:0] OFS_W3       = 32'h0000_000C;
    localparam logic [31:0] OFS_TS_LO    = 32'h0000_0018;
    localparam logic [31:0] OFS_TS_HI    = 32'h0000_001C;
    localparam logic [31:0] STRIDE_BASIC = 32'h0000_0010;
    localparam logic [31:0] STRIDE_ENH   = 32'h0000_0020;
    localparam logic [31:0] PTR_STEP     = 32'h0000_0004;
    localparam logic [12:0] WORD_BYTES   = 13'h0004;
    localparam logic [13:0] CNT_STEP     = 14'h0004;

    typedef enum logic [3:0] {
        S_STOP, S_SUSP, S_D0, S_D1, S_D2, S_D3, S_CHK,
        S_XFER, S_MOVE, S_TSL, S_TSH, S_WB, S_ERR
    } edd_state_t;

    typedef struct packed {
        edd_state_t  st;
        logic [31:0] base;
        logic [31:0] cur;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] b1;
        logic [31:0] b2;
        logic [31:0] ptr;
        logic [31:0] dat;
        logic [12:0] left;
        logic [13:0] cnt;
        logic        sel;
        logic        last;
        logic        err;
        logic        fs;
        logic        poll;
        logic        berr;
    } edd_eng_t;

    typedef struct packed {
        edd_eng_t [1:0] eng;
        logic [2:0]     ctrl;
        logic           aw_ok;
        logic           w_ok;
        logic [7:0]     awa;
        logic [31:0]    wd;
        logic [3:0]     ws;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        logic           mreq;
        logic           mwe;
        logic           msel;
        logic           mown;
        logic [31:0]    maddr;
        logic [31:0]    mwdata;
    } edd_all_t;

endpackage

// [dv/edd_mem_model.sv]
`timescale 1ns/1ps
module edd_mem_model (
    // memory port of the engine
    input  wire logic        aclk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output logic             mem_err
);
    logic [31:0] m [256];
    logic        slow;
    initial begin
        {mem_ack, mem_rdata, mem_err, slow} = '0;
        foreach (m[k]) m[k] = '0;
        // host fills sizes and pointers first, ownership last
        m[1] = 32'h0000_0008;
        m[2] = 32'h2000_0100;
        m[64] = 32'h1234_5678;
        m[65] = 32'h9ABC_DEF0;
        m[17] = 32'h0004_8004;
        m[18] = 32'h2000_0200;
        m[19] = 32'h2000_0204;
        m[0] = 32'hA020_0000;
        m[16] = 32'h8000_0000;
    end
    // answers come one or two cycles after a request, on a cycle where slow is set; data is scrambled while idle
    always @(posedge aclk) begin
        slow <= ~slow;
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && slow) begin
            mem_ack <= 1'b1;
            // only the modelled window of on-chip memory answers cleanly
            mem_err <= mem_addr[31:10] != 22'h08_0000;
            mem_rdata <= m[mem_addr[9:2]];
            if (mem_we) m[mem_addr[9:2]] <= mem_wdata;
        end
    end
endmodule

// [dv/edd_dma_asserts.sv]
`timescale 1ns/1ps
module edd_dma_asserts (
    // watched ports
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_awready,
    input wire logic        s_wready,
    input wire logic        s_bvalid,
    input wire logic        s_bready,
    input wire logic        s_arready,
    input wire logic        s_rvalid,
    input wire logic        s_rready,
    input wire logic [31:0] s_rdata,
    input wire logic        mem_req,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_addr,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [31:0] tx_data,
    input wire logic        rx_valid,
    input wire logic        rx_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_req; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_req: assert property (p_req) else $error("mem request dropped");
    property p_gap; mem_req && mem_ack |=> !mem_req; endproperty
    a_gap: assert property (p_gap) else $error("no idle after ack");
    property p_bv; s_bvalid && !s_bready |=> s_bvalid; endproperty
    a_bv: assert property (p_bv) else $error("bvalid dropped");
    property p_rv; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_rv: assert property (p_rv) else $error("read data dropped");
    property p_ar; s_rvalid |-> !s_arready; endproperty
    a_ar: assert property (p_ar) else $error("arready while busy");
    property p_aw; s_bvalid |-> !s_awready && !s_wready; endproperty
    a_aw: assert property (p_aw) else $error("write taken while busy");
    property p_tx; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_tx: assert property (p_tx) else $error("tx word dropped");
    property p_rx; rx_ready && !rx_valid |=> rx_ready; endproperty
    a_rx: assert property (p_rx) else $error("rx wait abandoned");
    c_wr: cover property (s_bvalid && s_bready);
    c_tx: cover property (tx_valid && tx_ready);
    c_rx: cover property (rx_valid && rx_ready);
endmodule
bind edd_dma edd_dma_asserts u_edd_dma_asserts (.*);

// [dv/tb_edd_dma.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_edd_dma;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, rx_last, rx_err, rx_valid;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_req, mem_we, mem_ack, mem_err, tx_last, tx_valid;
    logic rx_ready;
    // the mac side toggles ready on its own; only that process drives it
    logic tx_ready = 1'b0;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, mem_addr, mem_wdata, mem_rdata, tx_data, rx_data, d, txw[4];
    logic [1:0] s_bresp, s_rresp, r, b;
    logic [3:0] s_wstrb;
    logic [63:0] ts_in;
    logic txl[4];
    int miscompares, checks_done, n_tx, cyc, i;
    edd_dma u_edd_dma (.*);
    edd_mem_model u_edd_mem_model (.*);
    initial begin aclk = 0; forever #5 aclk = ~aclk; end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin miscompares++; summarize(); end
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready && n_tx < 4) begin txw[n_tx] = tx_data; txl[n_tx] = tx_last; n_tx++; end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_awaddr <= a;
        s_wdata <= v;
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        b = s_bresp;
        s_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        s_araddr <= a;
        {s_arvalid, s_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        v = s_rdata;
        e = s_rresp;
        s_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rxw(input logic [31:0] v, input logic l);
        {rx_data, rx_last, rx_valid} <= {v, l, 1'b1};
        do @(posedge aclk); while (!rx_ready);
        {rx_data, rx_valid} <= {~v, 1'b0};
        @(posedge aclk);
    endtask
    initial begin
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, rx_valid, rx_last, rx_err, aresetn} = '0;
        {s_awaddr, s_araddr, s_wdata, rx_data, ts_in} = '0;
        s_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wr(edd_pkg::REG_TX_LIST, 32'h2000_0000);
        `CHK("wr_okay", edd_pkg::RESP_OKAY, b)
        rd(edd_pkg::REG_TX_LIST, d, r);
        `CHK("tx_list", 32'h2000_0000, d)
        wr(edd_pkg::REG_RX_LIST, 32'h2000_0040);
        rd(8'h20, d, r);
        `CHK("unmapped_resp", edd_pkg::RESP_SLVERR, r)
        wr(8'h20, 32'h0000_0000);
        `CHK("unmapped_wr", edd_pkg::RESP_SLVERR, b)
        wr(edd_pkg::REG_CTRL, 32'h0000_0003);
        for (i = 0; i < 500 && n_tx < 2; i++) @(posedge aclk);
        `CHK("tx_word0", 32'h1234_5678, txw[0])
        `CHK("tx_last", 2'b10, {txl[1], txl[0]})
        for (i = 0; i < 30; i++) begin rd(edd_pkg::REG_STAT, d, r); if (d[0]) break; end
        `CHK("tx_suspended", 1'b1, d[0])
        `CHK("tx_own", 1'b0, u_edd_mem_model.m[0][31])
        $display("test tx_ring done");
        u_edd_mem_model.m[0][31] = 1'b1;
        wr(edd_pkg::REG_TX_POLL, 32'h0000_0001);
        for (i = 0; i < 500 && n_tx < 4; i++) @(posedge aclk);
        `CHK("tx_resumed", 32'h9ABC_DEF0, txw[3])
        $display("test tx_poll done");
        rxw(32'h0000_0011, 1'b0);
        rxw(32'h0000_0022, 1'b1);
        for (i = 0; i < 300 && u_edd_mem_model.m[16][31]; i++) @(posedge aclk);
        `CHK("rx_buf1", 32'h0000_0011, u_edd_mem_model.m[128])
        `CHK("rx_buf2", 32'h0000_0022, u_edd_mem_model.m[129])
        `CHK("rx_own_len", 16'h0008, u_edd_mem_model.m[16][31:16])
        `CHK("rx_last_seg", 1'b1, u_edd_mem_model.m[16][8])
        $display("test rx_ring done");
        // hand back the rx descriptor with a buffer outside on-chip memory
        u_edd_mem_model.m[18] = 32'h1000_0000;
        u_edd_mem_model.m[16][31] = 1'b1;
        wr(edd_pkg::REG_RX_POLL, 32'h0000_0001);
        for (i = 0; i < 30; i++) begin rd(edd_pkg::REG_STAT, d, r); if (d[3]) break; end
        `CHK("rx_bus_err", 2'b10, {d[3], d[1]})
        wr(edd_pkg::REG_STAT, 32'h0000_0008);
        rd(edd_pkg::REG_STAT, d, r);
        `CHK("berr_clear", 1'b0, d[3])
        $display("test rx_poll_err done");
        summarize();
    end
endmodule
